// [core/dmr_defs.svh]
/*
 Register indices, field positions, reset values and timing counts of the
 datapath mode register bank. Assumes a 50 MHz mclk.
*/
`ifndef DMR_DEFS_SVH
`define DMR_DEFS_SVH

`define DMR_IDX_DPCTL 8'h22
`define DMR_IDX_MODE 8'h23
`define DMR_IDX_PSTS 8'h30
`define DMR_IDX_BCERR 8'h31

`define DMR_DP_HOLD 7
`define DMR_DP_PASS 6
`define DMR_DP_SENSE 5
`define DMR_DP_AOFF 4
`define DMR_DP_4CSRC 3
`define DMR_DP_W18 2
`define DMR_DP_INBAND 1
`define DMR_DP_4CH 0

`define DMR_MD_CKSUM 7
`define DMR_MD_RATESEL 6
`define DMR_MD_AUTOAUD 5
`define DMR_MD_FAST 4
`define DMR_MD_COAX 3
`define DMR_MD_RPTR 2

`define DMR_PS_CKFAIL 0
`define DMR_AUX_4CH 0
`define DMR_AUX_INBAND 1

`define DMR_DPCTL_RST 8'h00
`define DMR_AUTOAUD_RST 1'b1
`define DMR_MASK18 24'hfcfcfc

`define DMR_CLK_PERIOD_NS 20
`define DMR_SETTLE_NS 10000
`define DMR_SETTLE_CYC (`DMR_SETTLE_NS / `DMR_CLK_PERIOD_NS)

`endif

// [core/dmr_pkg.sv]
/*
 Types shared by the datapath mode register bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dmr_pkg;
	typedef enum logic [1:0] {DMR_RATE_DIV4, DMR_RATE_DIV2, DMR_RATE_FAST} dmr_rate_type;
	typedef enum logic {DMR_STRAP_WAIT, DMR_STRAP_DONE} dmr_strap_type;
endpackage

// [core/dmr_strap_capture.sv]
/*
 Catches the decoded mode strap levels once, at the first edge after reset.
 Assumes the strap levels are stable around reset release.
*/
`timescale 1ns/10ps
module dmr_strap_capture (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Strap levels
	input wire logic strapFast,
	input wire logic strapCoax,
	input wire logic strapRepeater,
	// Captured values
	output logic strapLoad,
	output logic heldFast,
	output logic heldCoax,
	output logic heldRepeater
);
	dmr_pkg::dmr_strap_type state_r, state_nxt;
	logic load_r, load_nxt;
	logic [2:0] held_r, held_nxt;

	always_comb begin
		state_nxt = state_r;
		load_nxt = 1'b0;
		held_nxt = held_r;
		// Sampled by a clocked process so reset only ever loads constants
		unique case (state_r)
			dmr_pkg::DMR_STRAP_WAIT: begin
				held_nxt = {strapFast, strapCoax, strapRepeater};
				load_nxt = 1'b1;
				state_nxt = dmr_pkg::DMR_STRAP_DONE;
			end
			dmr_pkg::DMR_STRAP_DONE: begin
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_r <= dmr_pkg::DMR_STRAP_WAIT;
			load_r <= 1'b0;
			held_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			load_r <= load_nxt;
			held_r <= held_nxt;
		end
	end

	assign strapLoad = load_r;
	assign heldFast = held_r[2];
	assign heldCoax = held_r[1];
	assign heldRepeater = held_r[0];
endmodule

// [core/dmr_line_checksum.sv]
/*
 Sums the bytes of each video line and compares the sum with the checksum
 byte that follows the line. Assumes lineEnd is a one-cycle pulse.
*/
`timescale 1ns/10ps
module dmr_line_checksum (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Line data
	input wire logic checkEn,
	input wire logic pixValid,
	input wire logic [23:0] pixData,
	input wire logic lineEnd,
	input wire logic [7:0] lineSum,
	// Result
	output logic mismatch
);
	logic [7:0] sum_r, sum_nxt;
	logic bad_r, bad_nxt;

	always_comb begin
		sum_nxt = sum_r;
		bad_nxt = 1'b0;
		if (lineEnd) begin
			bad_nxt = checkEn && (sum_r != lineSum);
			sum_nxt = 8'h00;
		end else if (pixValid) begin
			sum_nxt = 8'(sum_r + pixData[7:0] + pixData[15:8] + pixData[23:16]);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sum_r <= 8'h00;
			bad_r <= 1'b0;
		end else begin
			sum_r <= sum_nxt;
			bad_r <= bad_nxt;
		end
	end

	assign mismatch = bad_r;
endmodule

// [core/dmr_mode_regs.sv]
/*
 Datapath control and receiver mode registers of a video link receiver, with
 the pixel path, audio mode and return link rate logic they steer.
 Assumes a classic Wishbone master on mclk and forward channel, pixel and
 strap inputs synchronous to mclk.
*/
`timescale 1ns/10ps
`include "dmr_defs.svh"
module dmr_mode_regs (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Wishbone slave
	input wire logic [9:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Forward channel configuration from the remote serializer
	input wire logic fcCfgValid,
	input wire logic [6:0] fcCfg,
	// Mode strap, already decoded
	input wire logic strapFast,
	input wire logic strapCoax,
	input wire logic strapRepeater,
	// Incoming pixel stream
	input wire logic [23:0] pixelIn,
	input wire logic pixelValidQualifier,
	input wire logic lineEnd,
	input wire logic [7:0] lineSum,
	// Packetized audio and aux codes
	input wire logic audioPktValid,
	input wire logic [23:0] audioPktData,
	input wire logic auxCodeValid,
	input wire logic [1:0] auxCode,
	// Return link error pulses
	input wire logic returnLinkErr,
	// Pixel output pins
	output logic [23:0] pixelOut,
	output logic pixelOutValid,
	output logic audioOnPins,
	// Mode outputs
	output logic protectionEnable,
	output logic audioFourChan,
	output logic audioInBand,
	output logic video18Bit,
	output logic coaxCable,
	output logic repeaterMode,
	output dmr_pkg::dmr_rate_type returnLinkRate,
	output logic returnLinkSettling
);
	// Bus
	logic ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic busReq, busWr;
	logic [7:0] regIdx;
	// Registers
	logic [7:0] dpCtl_r, dpCtl_nxt;
	logic cksumEn_r, cksumEn_nxt;
	logic rateSel_r, rateSel_nxt;
	logic autoAud_r, autoAud_nxt;
	logic fast_r, fast_nxt;
	logic coax_r, coax_nxt;
	logic ckFail_r, ckFail_nxt;
	logic [7:0] bcErrCnt_r, bcErrCnt_nxt;
	logic [15:0] settle_r, settle_nxt;
	logic settling_r, settling_nxt;
	logic [1:0] aux_r, aux_nxt;
	// Datapath outputs
	logic [23:0] pixOut_r, pixOut_nxt;
	logic pixValid_r, pixValid_nxt;
	logic audPins_r, audPins_nxt;
	logic prot_r, prot_nxt;
	logic four_r, four_nxt;
	logic inBand_r, inBand_nxt;
	logic w18_r, w18_nxt;
	dmr_pkg::dmr_rate_type rate_r, rate_nxt;
	// Internal
	logic strapLoad, heldFast, heldCoax, heldRepeater;
	logic ckMismatch;
	logic qualActive;
	logic [7:0] modeRead;

	// Drops the two low bits of each colour in 18-bit mode
	function automatic logic [23:0] fitWidth(input logic [23:0] d, input logic is18);
		fitWidth = is18 ? (d & `DMR_MASK18) : d;
	endfunction

	// Settling time counts in cycles; the window only masks error counting
	function automatic logic [15:0] settleLoad();
		settleLoad = 16'(`DMR_SETTLE_CYC);
	endfunction

	dmr_strap_capture strapCap (
		.mclk(mclk),
		.nrst(nrst),
		.strapFast(strapFast),
		.strapCoax(strapCoax),
		.strapRepeater(strapRepeater),
		.strapLoad(strapLoad),
		.heldFast(heldFast),
		.heldCoax(heldCoax),
		.heldRepeater(heldRepeater)
	);

	dmr_line_checksum lineCheck (
		.mclk(mclk),
		.nrst(nrst),
		.checkEn(cksumEn_r),
		.pixValid(qualActive && !dpCtl_r[`DMR_DP_PASS]),
		.pixData(pixelIn),
		.lineEnd(lineEnd),
		.lineSum(lineSum),
		.mismatch(ckMismatch)
	);

	assign regIdx = wb_adr_i[9:2];
	assign busReq = wb_cyc_i && wb_stb_i && !ack_r;
	// Writes land at the edge that sees ack high, where the master completes
	assign busWr = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
	assign qualActive = pixelValidQualifier ^ dpCtl_r[`DMR_DP_SENSE];
	assign modeRead = {cksumEn_r, rateSel_r, autoAud_r, fast_r, coax_r, heldRepeater, 2'b00};

	// Bus answer: one wait state, ack for one cycle, unmapped reads zero
	always_comb begin
		ack_nxt = busReq;
		rdat_nxt = rdat_r;
		if (busReq && !wb_we_i) begin
			unique case (regIdx)
				`DMR_IDX_DPCTL: rdat_nxt = {24'h000000, dpCtl_r};
				`DMR_IDX_MODE: rdat_nxt = {24'h000000, modeRead};
				`DMR_IDX_PSTS: rdat_nxt = {31'h00000000, ckFail_r};
				`DMR_IDX_BCERR: rdat_nxt = {24'h000000, bcErrCnt_r};
				default: rdat_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h00000000;
		end else begin
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	// Datapath control: software write wins over a same-cycle remote load
	always_comb begin
		dpCtl_nxt = dpCtl_r;
		if (busWr && regIdx == `DMR_IDX_DPCTL) begin
			dpCtl_nxt = wb_dat_i[7:0];
		end else if (fcCfgValid && !dpCtl_r[`DMR_DP_HOLD]) begin
			dpCtl_nxt = {dpCtl_r[`DMR_DP_HOLD], fcCfg};
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dpCtl_r <= `DMR_DPCTL_RST;
		end else begin
			dpCtl_r <= dpCtl_nxt;
		end
	end

	// Receiver mode register and return link rate
	always_comb begin
		cksumEn_nxt = cksumEn_r;
		rateSel_nxt = rateSel_r;
		autoAud_nxt = autoAud_r;
		fast_nxt = fast_r;
		coax_nxt = coax_r;
		settle_nxt = settle_r;
		rate_nxt = rate_r;
		if (settle_r != 16'h0000) begin
			settle_nxt = 16'(settle_r - 16'h0001);
		end
		if (strapLoad) begin
			fast_nxt = heldFast;
			coax_nxt = heldCoax;
		end else if (busWr && regIdx == `DMR_IDX_MODE) begin
			cksumEn_nxt = wb_dat_i[`DMR_MD_CKSUM];
			rateSel_nxt = wb_dat_i[`DMR_MD_RATESEL];
			autoAud_nxt = wb_dat_i[`DMR_MD_AUTOAUD];
			fast_nxt = wb_dat_i[`DMR_MD_FAST];
			coax_nxt = wb_dat_i[`DMR_MD_COAX];
		end
		if (fast_nxt) begin
			rate_nxt = dmr_pkg::DMR_RATE_FAST;
		end else if (rateSel_nxt) begin
			rate_nxt = dmr_pkg::DMR_RATE_DIV2;
		end else begin
			rate_nxt = dmr_pkg::DMR_RATE_DIV4;
		end
		// A rate change opens a window in which return link errors are ignored
		if (rate_nxt != rate_r) begin
			settle_nxt = settleLoad();
		end
		// Registered so the settling port comes straight from a flop
		settling_nxt = settle_nxt != 16'h0000;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cksumEn_r <= 1'b0;
			rateSel_r <= 1'b0;
			autoAud_r <= `DMR_AUTOAUD_RST;
			fast_r <= 1'b0;
			coax_r <= 1'b0;
			settle_r <= 16'h0000;
			settling_r <= 1'b0;
			rate_r <= dmr_pkg::DMR_RATE_DIV4;
		end else begin
			cksumEn_r <= cksumEn_nxt;
			rateSel_r <= rateSel_nxt;
			autoAud_r <= autoAud_nxt;
			fast_r <= fast_nxt;
			coax_r <= coax_nxt;
			settle_r <= settle_nxt;
			settling_r <= settling_nxt;
			rate_r <= rate_nxt;
		end
	end

	// Status: hardware set wins over a software clear in the same cycle
	always_comb begin
		ckFail_nxt = ckFail_r;
		bcErrCnt_nxt = bcErrCnt_r;
		if (busWr && regIdx == `DMR_IDX_PSTS && wb_dat_i[`DMR_PS_CKFAIL]) begin
			ckFail_nxt = 1'b0;
		end
		if (ckMismatch) begin
			ckFail_nxt = 1'b1;
		end
		if (busWr && regIdx == `DMR_IDX_BCERR) begin
			bcErrCnt_nxt = 8'h00;
		end
		// Counter saturates so a long error storm cannot wrap back to small
		if (returnLinkErr && settle_r == 16'h0000 && bcErrCnt_nxt != 8'hff) begin
			bcErrCnt_nxt = 8'(bcErrCnt_nxt + 8'h01);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ckFail_r <= 1'b0;
			bcErrCnt_r <= 8'h00;
		end else begin
			ckFail_r <= ckFail_nxt;
			bcErrCnt_r <= bcErrCnt_nxt;
		end
	end

	// Audio mode: aux codes steer it when auto mode is on
	always_comb begin
		aux_nxt = aux_r;
		if (auxCodeValid) begin
			aux_nxt = auxCode;
		end
		if (autoAud_r) begin
			four_nxt = aux_r[`DMR_AUX_4CH];
			inBand_nxt = aux_r[`DMR_AUX_INBAND];
		end else begin
			four_nxt = dpCtl_r[`DMR_DP_4CSRC] && dpCtl_r[`DMR_DP_4CH];
			inBand_nxt = dpCtl_r[`DMR_DP_INBAND];
		end
		w18_nxt = dpCtl_r[`DMR_DP_W18];
		prot_nxt = !dpCtl_r[`DMR_DP_PASS];
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			aux_r <= 2'b00;
			four_r <= 1'b0;
			inBand_r <= 1'b0;
			w18_r <= 1'b0;
			prot_r <= 1'b0;
		end else begin
			aux_r <= aux_nxt;
			four_r <= four_nxt;
			inBand_r <= inBand_nxt;
			w18_r <= w18_nxt;
			prot_r <= prot_nxt;
		end
	end

	// Pixel path, one register stage
	always_comb begin
		pixOut_nxt = pixOut_r;
		pixValid_nxt = 1'b0;
		audPins_nxt = 1'b0;
		if (dpCtl_r[`DMR_DP_PASS]) begin
			pixOut_nxt = fitWidth(pixelIn, dpCtl_r[`DMR_DP_W18]);
			pixValid_nxt = 1'b1;
		end else if (qualActive) begin
			pixOut_nxt = fitWidth(pixelIn, dpCtl_r[`DMR_DP_W18]);
			pixValid_nxt = 1'b1;
		end else if (audioPktValid && !dpCtl_r[`DMR_DP_AOFF]) begin
			pixOut_nxt = fitWidth(audioPktData, dpCtl_r[`DMR_DP_W18]);
			audPins_nxt = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pixOut_r <= 24'h000000;
			pixValid_r <= 1'b0;
			audPins_r <= 1'b0;
		end else begin
			pixOut_r <= pixOut_nxt;
			pixValid_r <= pixValid_nxt;
			audPins_r <= audPins_nxt;
		end
	end

	assign wb_dat_o = rdat_r;
	assign wb_ack_o = ack_r;
	assign pixelOut = pixOut_r;
	assign pixelOutValid = pixValid_r;
	assign audioOnPins = audPins_r;
	assign protectionEnable = prot_r;
	assign audioFourChan = four_r;
	assign audioInBand = inBand_r;
	assign video18Bit = w18_r;
	assign coaxCable = coax_r;
	assign repeaterMode = heldRepeater;
	assign returnLinkRate = rate_r;
	assign returnLinkSettling = settling_r;
endmodule

// [verif/dmr_mode_checker.sv]
/*
 Port-level checks of the mode register bank.
 Assumes one mclk domain; bound to dmr_mode_regs.
*/
`timescale 1ns/10ps
module dmr_mode_checker (
	// Clock, reset
	input wire logic mclk,
	input wire logic nrst,
	// Bus
	input wire logic [9:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Stimulus
	input wire logic fcCfgValid,
	input wire logic [6:0] fcCfg,
	input wire logic pixelValidQualifier,
	input wire logic audioPktValid,
	// Outputs
	input wire logic pixelOutValid,
	input wire logic audioOnPins,
	input wire logic protectionEnable,
	input wire logic video18Bit,
	input wire dmr_pkg::dmr_rate_type returnLinkRate,
	input wire logic returnLinkSettling
);
	// Shadow of datapath control, so no internal probes are needed
	logic [7:0] dpR;
	logic [7:0] dpNxt;
	wire wrOk = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
	wire [1:0] wrRate = wb_dat_i[4] ? 2'd2 : {1'b0, wb_dat_i[6]};
	always_comb begin
		dpNxt = dpR;
		if (wrOk && wb_adr_i[9:2] == 8'h22) begin
			dpNxt = wb_dat_i[7:0];
		end else if (fcCfgValid && !dpR[7]) begin
			dpNxt = {dpR[7], fcCfg};
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dpR <= 8'h00;
		end else begin
			dpR <= dpNxt;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence busTake;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ackPulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	ack_once_a: assert property (busTake |=> ackPulse) else $error("ack not one cycle");
	width_sel_a: assert property (video18Bit == $past(dpR[2])) else $error("width wrong");
	pass_all_a: assert property (dpR[6] |=> pixelOutValid && !audioOnPins && !protectionEnable)
		else $error("passthrough wrong");
	sense_valid_a: assert property (!dpR[6] && !audioPktValid |=>
		pixelOutValid == $past(pixelValidQualifier ^ dpR[5])) else $error("sense wrong");
	audio_pins_a: assert property (!dpR[6] && !(pixelValidQualifier ^ dpR[5]) && audioPktValid |=>
		audioOnPins != $past(dpR[4])) else $error("audio pins wrong");
	rate_sel_a: assert property (wrOk && wb_adr_i[9:2] == 8'h23 |=>
		returnLinkRate == $past(wrRate)) else $error("rate wrong");
	settle_win_a: assert property ($changed(returnLinkRate) && $past(nrst) |->
		##1 returnLinkSettling [*8]) else $error("no settling");
	reserved_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h23 |->
		wb_dat_o[1:0] == 2'b00) else $error("reserved bits set");
endmodule
bind dmr_mode_regs dmr_mode_checker chk (.*);

// [verif/dmr_remote_ser.sv]
/*
 Remote serializer model: sends configuration words on the forward channel.
 Assumes send requests from the bench on mclk.
*/
`timescale 1ns/10ps
module dmr_remote_ser (
	// Clock, reset
	input wire logic mclk,
	input wire logic nrst,
	// Bench request
	input wire logic sendReq,
	input wire logic [6:0] sendWord,
	// Forward channel
	output logic fcCfgValid,
	output logic [6:0] fcCfg
);
	// Word wanders between sends; it means nothing without the pulse
	// Rate is only changed locally, so no auto-acknowledge step is needed
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fcCfgValid <= 1'b0;
			fcCfg <= 7'h00;
		end else begin
			fcCfgValid <= sendReq;
			fcCfg <= sendReq ? sendWord : ~fcCfg;
		end
	end
endmodule

// [verif/deser_datapath_mode_regs_bench.sv]
/*
 Self-checking bench for the mode register bank.
 Assumes design, checker and serializer model compiled first.
*/
`timescale 1ns/10ps
`include "dmr_defs.svh"
module deser_datapath_mode_regs_bench;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [9:0] wb_adr_i = 10'h000;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, fcCfgValid, sendReq = 1'b0;
	logic [6:0] fcCfg, sendWord = 7'h00;
	logic strapFast, strapCoax, strapRepeater, lineEnd = 1'b0, auxCodeValid = 1'b0, returnLinkErr = 1'b0;
	logic [23:0] pixelIn = 24'h0, audioPktData = 24'h0, pixelOut, pd, ad;
	logic pixelValidQualifier = 1'b0, audioPktValid = 1'b0, act, au;
	logic [7:0] lineSum = 8'h00, dp, md, rd;
	logic [1:0] auxCode = 2'b00;
	logic pixelOutValid, audioOnPins, protectionEnable, audioFourChan, audioInBand, video18Bit;
	logic coaxCable, repeaterMode, returnLinkSettling;
	dmr_pkg::dmr_rate_type returnLinkRate;
	logic [7:0] rv [3] = '{8'h44, 8'hdb, 8'h00};
	logic [1:0] rr [3] = '{2'd1, 2'd2, 2'd0};
	int n_errors = 0;
	int checked = 0;
	int seed = 1;
	int i;
	dmr_mode_regs dut (.*);
	dmr_remote_ser far (.*);
	always #10 mclk = ~mclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] sel);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= sel;
		// No limit of its own: a missing ack is ended by the watchdog
		do begin
			@(posedge mclk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'h1);
	endtask
	task automatic rdx(input logic [7:0] idx, input logic [7:0] want);
		bus(1'b0, idx, 8'h00, 4'hf);
		check(rd, want);
	endtask
	task automatic pulseIn(input int k);
		@(posedge mclk);
		if (k == 0) returnLinkErr <= 1'b1;
		else if (k == 1) auxCodeValid <= 1'b1;
		else sendReq <= 1'b1;
		@(posedge mclk);
		returnLinkErr <= 1'b0;
		auxCodeValid <= 1'b0;
		sendReq <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic lineOut(input logic [7:0] s);
		@(posedge mclk);
		pixelValidQualifier <= 1'b1;
		pixelIn <= 24'h102030;
		@(posedge mclk);
		pixelValidQualifier <= 1'b0;
		lineEnd <= 1'b1;
		lineSum <= s;
		@(posedge mclk);
		lineEnd <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Run is under a thousand cycles; this leaves wide margin
	initial begin
		#400000;
		n_errors++;
		end_of_test;
	end
	initial begin
		{strapFast, strapCoax, strapRepeater} = 3'($random(seed));
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		md = {3'b001, strapFast, strapCoax, strapRepeater, 2'b00};
		rdx(8'h23, md);
		rdx(8'h22, 8'h00);
		check(coaxCable, strapCoax);
		check(repeaterMode, strapRepeater);
		check(returnLinkRate, strapFast ? 2'd2 : 2'd0);
		@(posedge mclk);
		auxCode <= 2'b11;
		pulseIn(1);
		check({audioFourChan, audioInBand}, 2'b11);
		bus(1'b1, 8'h22, 8'hff, 4'he);
		rdx(8'h22, 8'h00);
		rdx(8'hff, 8'h00);
		for (i = 0; i < 3; i++) begin
			wr(8'h23, rv[i]);
			rdx(8'h23, (rv[i] & 8'hf8) | {5'h0, strapRepeater, 2'b00});
			check(returnLinkRate, rr[i]);
			check(coaxCable, rv[i][3]);
		end
		check(returnLinkSettling, 1'b1);
		pulseIn(0);
		rdx(8'h31, 8'h00);
		repeat (520) @(posedge mclk);
		pulseIn(0);
		rdx(8'h31, 8'h01);
		for (i = 0; i < 16; i++) begin
			dp = 8'h80 | i[7:0];
			wr(8'h22, dp);
			repeat (2) @(posedge mclk);
			#1 check(audioFourChan, dp[3] & dp[0]);
			check(audioInBand, dp[1]);
			check(video18Bit, dp[2]);
		end
		wr(8'h22, 8'h00);
		md = 8'($random(seed));
		sendWord <= md[6:0];
		pulseIn(2);
		rdx(8'h22, {1'b0, md[6:0]});
		wr(8'h22, 8'h80);
		sendWord <= ~md[6:0];
		pulseIn(2);
		rdx(8'h22, 8'h80);
		for (i = 0; i < 8; i++) begin
			dp = 8'h80 | (8'($random(seed)) & 8'h74);
			wr(8'h22, dp);
			repeat (16) begin
				@(posedge mclk);
				act = pixelValidQualifier ^ dp[5];
				au = audioPktValid;
				pd = pixelIn & (dp[2] ? `DMR_MASK18 : 24'hffffff);
				ad = audioPktData & (dp[2] ? `DMR_MASK18 : 24'hffffff);
				{pixelValidQualifier, audioPktValid} <= 2'($random(seed));
				pixelIn <= 24'($random(seed));
				audioPktData <= 24'($random(seed));
				#1;
				if (dp[6] || act) begin
					check({pixelOutValid, audioOnPins, pixelOut}, {2'b10, pd});
				end else begin
					check(audioOnPins, au & !dp[4]);
					check(pixelOutValid, 1'b0);
					if (au && !dp[4]) check(pixelOut, ad);
				end
				check(protectionEnable, !dp[6]);
			end
		end
		wr(8'h22, 8'h80);
		lineOut(8'h00);
		wr(8'h23, 8'h80);
		lineOut(8'h60);
		rdx(8'h30, 8'h00);
		lineOut(8'h61);
		rdx(8'h30, 8'h01);
		wr(8'h30, 8'h01);
		rdx(8'h30, 8'h00);
		end_of_test;
	end
endmodule
